// >>> rtl/rst_src_pkg.sv
package rst_src_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four: index * 4 = byte address
  localparam logic [7:0]  CAUSE_IDX      = 8'h00;
  localparam logic [7:0]  TRIG_IDX       = 8'h01;
  localparam logic [7:0]  KEY_IDX        = 8'h02;
  localparam logic [7:0]  FUSE_IDX       = 8'h03;
  localparam logic [7:0]  STATUS_IDX     = 8'h04;
  localparam logic [11:0] CAUSE_ADDR     = {2'b00, CAUSE_IDX, 2'b00};
  localparam logic [11:0] TRIG_ADDR      = {2'b00, TRIG_IDX, 2'b00};
  localparam logic [11:0] KEY_ADDR       = {2'b00, KEY_IDX, 2'b00};
  localparam logic [11:0] FUSE_ADDR      = {2'b00, FUSE_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR    = {2'b00, STATUS_IDX, 2'b00};

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int          POWERON_BIT    = 0;
  localparam int          BROWNOUT_BIT   = 1;
  localparam int          PIN_BIT        = 2;
  localparam int          WATCHDOG_BIT   = 3;
  localparam int          SOFT_BIT       = 4;
  localparam int          DEBUG_BIT      = 5;
  localparam int          FIRE_BIT       = 0;
  localparam logic [7:0]  IO_REG_KEY     = 8'hd8;
  localparam logic [2:0]  KEY_WINDOW     = 3'h4;
  localparam logic [5:0]  CAUSE_POR_VAL  = 6'h01;
  localparam logic [7:0]  TRIG_RST_VAL   = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ        = 250;
  localparam int          INIT_NS        = 64;
  localparam int          INIT_CYC       = (INIT_NS * CLK_MHZ) / 1000;

  // Sequencer states, Gray along the usual path
  typedef enum logic [1:0] {
    SEQ_RUN    = 2'b00,
    SEQ_SOURCE = 2'b01,
    SEQ_INIT   = 2'b11,
    SEQ_EXTRA  = 2'b10
  } seq_state_e;

  // Raw reset sources from the analog and peripheral side
  typedef struct packed {
    logic debug_req;
    logic soft_req;
    logic wdog_req;
    logic pin_low;
    logic brownout;
    logic poweron;
  } src_s;

  // Fuse-derived settings reloaded at every reset
  typedef struct packed {
    logic        pin_reset_fuse_field;
    logic        crc_at_start;
    logic [2:0]  startup_delay_setting;
  } fuse_s;

endpackage

// >>> rtl/reset_source_controller.sv
// Operation
// - Watchdog timeout causes system reset
// - Writing one to fire bit resets
// - Soft reset starts now, holds until done
// - Fire bit always reads zero
// - Debug reset only from external debugger
// - Every reset reloads fuses, resets logic
// - Debug logic reset only by supply
// - Source phase lasts while any active
// - Init sequence runs after all released
// - Startup delay only after supply reset
// - CRC scan lengthens init when enabled
// - Operates in active and sleep modes
// - Key then trigger within four instructions
// - Unlocked trigger writes are ignored
// - Write one clears cause flag
// - Power-on clears flags except power-on
// - Cause flags map to bits 5..0
// - After power-on only power-on flag set
// - No other flags before boot completes
// - Enabled pin holds reset while low
// - Power-on detector always enabled
//
// Register access over AXI4-Lite was left to the implementer.
module reset_source_controller
  import rst_src_pkg::*;
#(
  parameter int STARTUP_UNIT = 64,
  parameter int CRC_CYCLES   = 256
) (
  // Clock and reset
  input  wire logic                 REF_CLK_IN,
  input  wire logic                 SRST_IN,
  // Raw reset sources (asynchronous)
  input  wire rst_src_pkg::src_s    SOURCES_IN,
  // Fuse array contents, stable
  input  wire rst_src_pkg::fuse_s   FUSE_IN,
  // Instruction retire pulse for the key window
  input  wire logic                 INSN_DONE_IN,
  // AXI4-Lite slave
  input  wire logic [11:0]          AWADDR_IN,
  input  wire logic                 AWVALID_IN,
  output logic                      AWREADY_OUT,
  input  wire logic [31:0]          WDATA_IN,
  input  wire logic [3:0]           WSTRB_IN,
  input  wire logic                 WVALID_IN,
  output logic                      WREADY_OUT,
  output logic [1:0]                BRESP_OUT,
  output logic                      BVALID_OUT,
  input  wire logic                 BREADY_IN,
  input  wire logic [11:0]          ARADDR_IN,
  input  wire logic                 ARVALID_IN,
  output logic                      ARREADY_OUT,
  output logic [31:0]               RDATA_OUT,
  output logic [1:0]                RRESP_OUT,
  output logic                      RVALID_OUT,
  input  wire logic                 RREADY_IN,
  // Reset outputs
  output logic                      SYS_RST_OUT,
  output logic                      DEBUG_RST_OUT,
  output logic                      FUSE_LOAD_OUT,
  output rst_src_pkg::fuse_s        FUSE_OUT
);
  import rst_src_pkg::*;

  // ----------------------------------------------------------------
  // Source synchronisers
  // ----------------------------------------------------------------
  src_s       src_meta_reg;
  src_s       src_sync_reg;
  logic       soft_req_reg;
  logic       any_active;
  logic       supply_active;

  // Two flops per source; the first is read only by the second
  // Sources come from analog blocks, so nothing reads the raw inputs directly
  always_ff @(posedge REF_CLK_IN) begin
    src_meta_reg <= SOURCES_IN;
    src_sync_reg <= src_meta_reg;
  end

  // No sleep gating anywhere; the clock keeps running in every power mode
  assign supply_active = src_sync_reg.poweron | src_sync_reg.brownout;
  // Debug reset comes only from the pin-side debug port, never from the bus
  assign any_active = supply_active
                    | (src_sync_reg.pin_low & FUSE_IN.pin_reset_fuse_field)
                    | src_sync_reg.wdog_req
                    | src_sync_reg.debug_req
                    | soft_req_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_e state_reg;
  logic [15:0] cnt_reg;
  logic        supply_seen_reg;
  logic [15:0] extra_len;

  assign extra_len = 16'(FUSE_IN.startup_delay_setting) * 16'(STARTUP_UNIT);

  // Init and extra phases each wait out their own count; extra phase folds startup and CRC
  // A source that returns mid-sequence restarts the source phase in full
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state_reg       <= SEQ_SOURCE;
      cnt_reg         <= 16'h0000;
      supply_seen_reg <= 1'b1;
    end else begin
      case (state_reg)
        SEQ_RUN: begin
          if (any_active) begin
            state_reg       <= SEQ_SOURCE;
            supply_seen_reg <= supply_active;
          end
        end
        SEQ_SOURCE: begin
          if (supply_active) supply_seen_reg <= 1'b1;
          if (!any_active) begin
            state_reg <= SEQ_INIT;
            cnt_reg   <= 16'(INIT_CYC);
          end
        end
        SEQ_INIT: begin
          if (any_active) state_reg <= SEQ_SOURCE;
          else if (cnt_reg > 16'h0001) cnt_reg <= cnt_reg - 16'h0001;
          else begin
            state_reg <= SEQ_EXTRA;
            // Startup only after supply reset; CRC scan when fused on
            cnt_reg <= (supply_seen_reg ? extra_len : 16'h0000)
                     + (FUSE_IN.crc_at_start ? 16'(CRC_CYCLES) : 16'h0000);
          end
        end
        default: begin
          if (any_active) state_reg <= SEQ_SOURCE;
          else if (cnt_reg != 16'h0000) cnt_reg <= cnt_reg - 16'h0001;
          else state_reg <= SEQ_RUN;
        end
      endcase
    end
  end

  // Outputs: system reset held whole sequence, debug only on supply
  // FUSE_OUT moves only on the load pulse, so readers never see a half update
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      SYS_RST_OUT   <= 1'b1;
      DEBUG_RST_OUT <= 1'b1;
      FUSE_LOAD_OUT <= 1'b0;
      FUSE_OUT      <= '0;
    end else begin
      SYS_RST_OUT   <= (state_reg != SEQ_RUN) | any_active;
      DEBUG_RST_OUT <= supply_active;
      FUSE_LOAD_OUT <= (state_reg == SEQ_INIT) && (cnt_reg == 16'(INIT_CYC));
      if ((state_reg == SEQ_INIT) && (cnt_reg == 16'(INIT_CYC))) FUSE_OUT <= FUSE_IN;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_go;
  logic [2:0]  key_cnt_reg;
  logic [5:0]  cause_reg;
  logic        boot_done_reg;
  logic [5:0]  cause_set;
  logic [5:0]  cause_clr;

  assign wr_go = aw_held_reg & w_held_reg & ~BVALID_OUT;

  // Address and data taken in either order, response after both
  // Unmapped offsets answer SLVERR and change nothing
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      AWREADY_OUT <= 1'b0;
      WREADY_OUT  <= 1'b0;
      BVALID_OUT  <= 1'b0;
      BRESP_OUT   <= RESP_OKAY;
    end else begin
      AWREADY_OUT <= ~aw_held_reg & ~(AWVALID_IN & AWREADY_OUT);
      WREADY_OUT  <= ~w_held_reg & ~(WVALID_IN & WREADY_OUT);
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_held_reg <= 1'b1;
        w_data_reg <= WDATA_IN;
        w_strb_reg <= WSTRB_IN;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        BVALID_OUT  <= 1'b1;
        if (aw_addr_reg == CAUSE_ADDR || aw_addr_reg == TRIG_ADDR
            || aw_addr_reg == KEY_ADDR || aw_addr_reg == FUSE_ADDR
            || aw_addr_reg == STATUS_ADDR) BRESP_OUT <= RESP_OKAY;
        else BRESP_OUT <= RESP_SLVERR;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end

  // Key window counts retired instructions after the key write
  // Counting instructions, not clocks, keeps the window right when the CPU stalls
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      key_cnt_reg  <= 3'h0;
      soft_req_reg <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == KEY_ADDR && w_strb_reg[0]
          && w_data_reg[7:0] == IO_REG_KEY) key_cnt_reg <= KEY_WINDOW;
      else if (wr_go && aw_addr_reg == TRIG_ADDR) key_cnt_reg <= 3'h0;
      else if (INSN_DONE_IN && key_cnt_reg != 3'h0) key_cnt_reg <= key_cnt_reg - 3'h1;
      // Fire only inside the window, else dropped
      if (wr_go && aw_addr_reg == TRIG_ADDR && w_strb_reg[0]
          && w_data_reg[FIRE_BIT] && key_cnt_reg != 3'h0) soft_req_reg <= 1'b1;
      else if (state_reg == SEQ_SOURCE) soft_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cause flags
  // ----------------------------------------------------------------
  always_comb begin
    cause_set = 6'h00;
    cause_set[POWERON_BIT]  = src_sync_reg.poweron;
    cause_set[BROWNOUT_BIT] = src_sync_reg.brownout;
    cause_set[PIN_BIT]      = src_sync_reg.pin_low & FUSE_IN.pin_reset_fuse_field;
    cause_set[WATCHDOG_BIT] = src_sync_reg.wdog_req;
    cause_set[SOFT_BIT]     = soft_req_reg;
    cause_set[DEBUG_BIT]    = src_sync_reg.debug_req;
    cause_clr = 6'h00;
    if (wr_go && aw_addr_reg == CAUSE_ADDR && w_strb_reg[0]) begin
      cause_clr = w_data_reg[5:0];
    end
  end

  // Set wins over clear; power-on wipes the rest until boot is done
  // Limitation: a source still active when cleared sets its flag again
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      cause_reg     <= CAUSE_POR_VAL;
      boot_done_reg <= 1'b0;
    end else if (src_sync_reg.poweron) begin
      cause_reg     <= CAUSE_POR_VAL;
      boot_done_reg <= 1'b0;
    end else begin
      if (state_reg == SEQ_RUN) boot_done_reg <= 1'b1;
      if (boot_done_reg) cause_reg <= (cause_reg & ~cause_clr) | cause_set;
      else cause_reg <= cause_reg & ~cause_clr;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // Trigger register always reads zero
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= RESP_OKAY;
    end else begin
      ARREADY_OUT <= ~RVALID_OUT & ~(ARVALID_IN & ARREADY_OUT);
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RRESP_OUT  <= RESP_OKAY;
        if (ARADDR_IN == CAUSE_ADDR) RDATA_OUT <= {26'h0, cause_reg};
        else if (ARADDR_IN == TRIG_ADDR) RDATA_OUT <= 32'h0000_0000;
        else if (ARADDR_IN == KEY_ADDR) RDATA_OUT <= 32'h0000_0000;
        else if (ARADDR_IN == FUSE_ADDR) RDATA_OUT <= {27'h0, FUSE_OUT};
        else if (ARADDR_IN == STATUS_ADDR) RDATA_OUT <= {27'h0, key_cnt_reg, state_reg};
        else begin
          RDATA_OUT <= 32'h0000_0000;
          RRESP_OUT <= RESP_SLVERR;
        end
      end else if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Reset sources and the soft trigger
  fire_held_reset_a: assert property (soft_req_reg |-> ##[1:3] SYS_RST_OUT)
    else $error("soft reset did not assert system reset");
  unlock_needed_a: assert property ($rose(soft_req_reg) |-> $past(key_cnt_reg) != 3'h0)
    else $error("soft reset without unlock");
  wdog_reset_a: assert property (src_sync_reg.wdog_req |=> SYS_RST_OUT)
    else $error("watchdog did not reset");
  debug_keep_a: assert property (!supply_active |=> !DEBUG_RST_OUT)
    else $error("debug port reset by user source");
  por_flags_a: assert property (src_sync_reg.poweron |=> cause_reg == CAUSE_POR_VAL)
    else $error("power-on flags wrong");
  pin_cause_a: assert property (boot_done_reg && cause_set[PIN_BIT]
                                && !src_sync_reg.poweron |=> cause_reg[PIN_BIT])
    else $error("pin flag not set");
  trig_read_a: assert property (RVALID_OUT && $past(ARADDR_IN) == TRIG_ADDR
                                && $past(ARVALID_IN && ARREADY_OUT) |-> RDATA_OUT == 32'h0)
    else $error("trigger read nonzero");
  no_run_active_a: assert property (state_reg == SEQ_RUN && any_active
                                    |=> state_reg == SEQ_SOURCE)
    else $error("source ignored");
  run_after_init_a: assert property ($rose(state_reg == SEQ_RUN)
                                     |-> $past(state_reg) == SEQ_EXTRA)
    else $error("run entered without init");

  // Sequencer, outputs and fuse copy
  seq_hold_a: assert property (state_reg != SEQ_RUN |=> SYS_RST_OUT)
    else $error("system reset dropped inside the sequence");
  run_release_a: assert property (state_reg == SEQ_RUN && !any_active |=> !SYS_RST_OUT)
    else $error("system reset held after the sequence");
  supply_reset_a: assert property (supply_active
                                   |=> SYS_RST_OUT && DEBUG_RST_OUT)
    else $error("supply reset not applied");
  pin_hold_a: assert property (src_sync_reg.pin_low
                               && FUSE_IN.pin_reset_fuse_field |=> SYS_RST_OUT)
    else $error("pin reset not held");
  fuse_load_a: assert property ($rose(state_reg == SEQ_INIT) |=> FUSE_LOAD_OUT)
    else $error("fuse load pulse missing");
  fuse_copy_a: assert property (FUSE_LOAD_OUT |-> FUSE_OUT == $past(FUSE_IN))
    else $error("fuse copy wrong");
  extra_user_a: assert property ($rose(state_reg == SEQ_EXTRA) && !supply_seen_reg
                                 && !FUSE_IN.crc_at_start |-> cnt_reg == 16'h0000)
    else $error("start-up delay after user reset");
  extra_crc_a: assert property ($rose(state_reg == SEQ_EXTRA) && FUSE_IN.crc_at_start
                                |-> cnt_reg >= 16'(CRC_CYCLES))
    else $error("scan time missing");

  // Cause flags
  soft_cause_a: assert property (boot_done_reg && soft_req_reg
                                 && !src_sync_reg.poweron |=> cause_reg[SOFT_BIT])
    else $error("soft flag not set");
  clear_flag_a: assert property (!src_sync_reg.poweron && cause_clr != 6'h00
                                 |=> (cause_reg & $past(cause_clr & ~cause_set)) == 6'h00)
    else $error("flag not cleared by one");
  keep_flag_a: assert property (!src_sync_reg.poweron
                                |=> ($past(cause_reg & ~cause_clr) & ~cause_reg) == 6'h00)
    else $error("flag lost without a clear");
  boot_lock_a: assert property (!boot_done_reg && !src_sync_reg.poweron
                                |=> (cause_reg & ~$past(cause_reg)) == 6'h00)
    else $error("flag set before boot completed");
  por_only_a: assert property ($fell(src_sync_reg.poweron)
                               |-> cause_reg == CAUSE_POR_VAL)
    else $error("flags other than power-on set");

  // Responses stand until taken
  bvalid_hold_a: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT)
    else $error("write response dropped early");
  rvalid_hold_a: assert property (RVALID_OUT && !RREADY_IN |=> RVALID_OUT)
    else $error("read response dropped early");

  // Main scenarios
  soft_cov_c: cover property ($rose(soft_req_reg));
  wdog_cov_c: cover property (src_sync_reg.wdog_req && state_reg == SEQ_RUN);
  clear_cov_c: cover property (cause_clr != 6'h00);
  extra_cov_c: cover property (state_reg == SEQ_EXTRA && cnt_reg > 16'h0000);
  supply_cov_c: cover property ($rose(DEBUG_RST_OUT));

endmodule

// >>> verification/reset_source_model.sv
module reset_source_model
  import rst_src_pkg::*;
(
  // Clock
  input  wire logic          clk_in,
  // Requests from the bench
  input  wire logic [5:0]    want_in,
  input  wire logic          dbg_attached_in,
  input  wire logic          retire_in,
  // Toward the controller
  output rst_src_pkg::src_s  sources_out = '0,
  output logic               insn_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // Raw sources move just after the edge; levels, held as long as asked
  always_ff @(posedge clk_in) begin
    sources_out.poweron  <= want_in[POWERON_BIT];
    sources_out.brownout <= want_in[BROWNOUT_BIT];
    sources_out.pin_low  <= want_in[PIN_BIT];
    sources_out.wdog_req <= want_in[WATCHDOG_BIT];
    // Soft reset goes through the register, never a raw line
    sources_out.soft_req <= 1'b0;
    // Only an attached external debugger may raise this line
    sources_out.debug_req <= want_in[DEBUG_BIT] & dbg_attached_in;
  end

  // One retire pulse per instruction run by the software side
  always_ff @(posedge clk_in) begin
    insn_out <= retire_in;
  end
endmodule

// >>> verification/tb_top.sv
module tb_top;
  import rst_src_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 0, srst = 1, retire = 0, dbg = 1;
  logic [5:0] want = '0;
  fuse_s fuse = '0, fuse_q;
  src_s srcs;
  logic insn, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr_rdy, bv, arr, rv, sys_rst, dbg_rst, fload;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0] br, rr, resp;
  logic [31:0] v;
  int error_cnt = 0, compares = 0, cyc = 0, loads = 0, n, n_pin, n_wd;

  // ----------------------------------------------------------------
  // Clock, watchdog on the run, fuse-load counter
  // ----------------------------------------------------------------
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    loads += (fload === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  reset_source_model reset_source_model_inst (.clk_in(clk), .want_in(want),
    .dbg_attached_in(dbg), .retire_in(retire), .sources_out(srcs), .insn_out(insn));

  // Smaller start-up and scan counts keep the run short
  reset_source_controller #(.STARTUP_UNIT(8), .CRC_CYCLES(16)) reset_source_controller_inst (
    .REF_CLK_IN(clk), .SRST_IN(srst), .SOURCES_IN(srcs), .FUSE_IN(fuse),
    .INSN_DONE_IN(insn), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
    .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wr_rdy),
    .BRESP_OUT(br), .BVALID_OUT(bv), .BREADY_IN(bry), .ARADDR_IN(ara),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .RDATA_OUT(rd), .RRESP_OUT(rr),
    .RVALID_OUT(rv), .RREADY_IN(rry), .SYS_RST_OUT(sys_rst),
    .DEBUG_RST_OUT(dbg_rst), .FUSE_LOAD_OUT(fload), .FUSE_OUT(fuse_q));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_rdy) wv <= 0;
      if (bry && bv) break;
    end
    resp = br;
    bry <= 0;
  endtask

  task automatic axr(input logic [11:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rry && rv) break;
    end
    v = rd; resp = rr;
    rry <= 0;
  endtask

  // Cycles until the system reset drops; bounded
  task automatic boot(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (sys_rst !== 1'b0 && cnt < 2000);
    chk(cnt < 2000, 1);
  endtask

  // Raise one source, hold it, release, then time the boot
  task automatic src_rst(input int b, output int cnt);
    @(posedge clk);
    want[b] <= 1;
    repeat (12) @(posedge clk);
    chk(sys_rst, 1);
    chk(dbg_rst, b < 2);
    want[b] <= 0;
    boot(cnt);
    chk(cnt >= INIT_CYC, 1);
    chk(fuse_q, fuse);
  endtask

  task automatic retire_n(input int k);
    repeat (k) begin
      @(posedge clk) retire <= 1;
      @(posedge clk) retire <= 0;
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fuse <= '{pin_reset_fuse_field: 1'b1, crc_at_start: 1'b0, startup_delay_setting: 3'h1};
    repeat (5) @(posedge clk);
    srst <= 0;
    boot(n);
    axr(CAUSE_ADDR); chk(v, 32'h01);
    chk(resp, RESP_OKAY);
    axr(TRIG_ADDR);  chk(v, 32'h00);
    axr(12'h014);    chk(resp, RESP_SLVERR);
    axw(12'h014, 32'h3f); chk(resp, RESP_SLVERR);
    axr(CAUSE_ADDR); chk(v, 32'h01);
    axw(CAUSE_ADDR, 32'h00); axr(CAUSE_ADDR); chk(v, 32'h01);
    axw(CAUSE_ADDR, 32'h01); axr(CAUSE_ADDR); chk(v, 32'h00);
    $display("test registers done");

    // Trigger with no key, then with a key whose window ran out
    axw(TRIG_ADDR, 32'h01); repeat (30) @(posedge clk); chk(sys_rst, 0);
    axw(KEY_ADDR, {24'h0, IO_REG_KEY}); retire_n(4);
    axw(TRIG_ADDR, 32'h01); repeat (30) @(posedge clk); chk(sys_rst, 0);
    // Proper unlock: reset starts at once, debug logic untouched
    n = loads;
    axw(KEY_ADDR, {24'h0, IO_REG_KEY}); chk(resp, RESP_OKAY);
    axr(STATUS_ADDR); chk(v, 32'h10);
    axw(TRIG_ADDR, 32'h01);
    repeat (2) @(posedge clk);
    chk(sys_rst, 1);
    chk(dbg_rst, 0);
    boot(n_wd);
    chk(loads > n, 1);
    axr(TRIG_ADDR);  chk(v, 32'h00);
    axr(FUSE_ADDR);  chk(v, {27'h0, fuse});
    axr(CAUSE_ADDR); chk(v, 32'h10);
    axw(CAUSE_ADDR, 32'h3f);
    $display("test soft reset done");

    // Each raw source sets its own flag; supply resets take longer
    src_rst(PIN_BIT, n_pin);
    axr(CAUSE_ADDR); chk(v, 32'h04); axw(CAUSE_ADDR, 32'h3f);
    src_rst(WATCHDOG_BIT, n_wd);
    axr(CAUSE_ADDR); chk(v, 32'h08); axw(CAUSE_ADDR, 32'h3f);
    src_rst(DEBUG_BIT, n);
    axr(CAUSE_ADDR); chk(v, 32'h20); axw(CAUSE_ADDR, 32'h3f);
    src_rst(BROWNOUT_BIT, n);
    chk(n > n_pin, 1);
    axr(CAUSE_ADDR); chk(v, 32'h02); axw(CAUSE_ADDR, 32'h3f);
    $display("test sources done");

    // Memory scan at start-up lengthens the initialization
    fuse.crc_at_start <= 1'b1;
    src_rst(WATCHDOG_BIT, n);
    chk(n > n_wd, 1);
    // Pin ignored when its fuse is off
    fuse <= '{pin_reset_fuse_field: 1'b0, crc_at_start: 1'b0, startup_delay_setting: 3'h0};
    @(posedge clk) want[PIN_BIT] <= 1;
    repeat (30) @(posedge clk);
    chk(sys_rst, 0);
    want[PIN_BIT] <= 0;
    // Power-on wipes every other flag
    src_rst(POWERON_BIT, n);
    axr(CAUSE_ADDR); chk(v, 32'h01);
    $display("test fuses and power-on done");
    end_of_test();
  end
endmodule
